// >>> dv/energy_line_cycle_mode_control_bench.sv
`timescale 1ns/1ps

module energy_line_cycle_mode_control_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [line_cycle_mode_pkg::ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sv = 1'b0;
    logic [2:0][23:0] smp = '0;
    logic [2:0] zc = 3'h0;
    logic [15:0] hc = 16'h0002;
    logic [7:0] cfg;
    logic lcd;
    logic pfu;
    logic [31:0] rd;
    logic er;
    logic sd;
    logic sp;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;

    energy_line_cycle_mode_control u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sv), .active_power(smp), .reactive_power(smp),
        .apparent_power(smp), .fund_active_power(smp), .fund_reactive_power(smp),
        .zero_cross(zc), .half_cycle_count(hc), .active_energy_cycle_sel(cfg[0]),
        .reactive_energy_cycle_sel(cfg[1]), .apparent_energy_cycle_sel(cfg[2]),
        .crossing_phase_select(cfg[5:3]), .clear_on_read_en(cfg[6]),
        .power_factor_source_sel(cfg[7]), .line_cycle_done(lcd), .pf_update(pfu)
    );

    always #2 pclk = ~pclk;

    // A hung handshake ends here rather than stalling the run
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            failures = failures + 1;
            results();
        end
    end

    task automatic results();
        $display("failures=%0d comparisons=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Entered just after a rising edge; the request holds until pready is seen
    task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic cfg_wr(input logic [7:0] d);
        apb(1'b1, line_cycle_mode_pkg::CFG_ADDR, {24'h0, d});
    endtask

    function automatic logic [19:0] acc_addr(input int i);
        return {line_cycle_mode_pkg::ACC_BASE_INDEX + 18'(i), 2'b00};
    endfunction

    task automatic acc_rd(input int i, input logic [31:0] e);
        apb(1'b0, acc_addr(i), 32'h0);
        chk("accumulator", e, rd);
    endtask

    // Same sample on every phase and bus; done and pf flags caught mid-cycle
    task automatic samp(input logic [23:0] v, input logic [2:0] z);
        sv <= 1'b1;
        smp <= {v, v, v};
        zc <= z;
        #1;
        sd = lcd;
        sp = pfu;
        @(posedge pclk);
        sv <= 1'b0;
        zc <= 3'h0;
        @(posedge pclk);
    endtask

    task automatic t_reset();
        apb(1'b0, line_cycle_mode_pkg::CFG_ADDR, 32'h0);
        chk("cfg reset read", 32'h78, rd);
        chk("cfg reset outs", 32'h78, {24'h0, cfg});
    endtask

    // Bit 7 alone would break the energy power factor setup, so bits 0 and 2 ride along
    task automatic t_fields();
        logic [7:0] v;
        for (int k = 0; k < 8; k++)
        begin
            v = 8'(1 << k) | ((k == 7) ? 8'h05 : 8'h00);
            cfg_wr(v);
            apb(1'b0, line_cycle_mode_pkg::CFG_ADDR, 32'h0);
            chk("cfg read", {24'h0, v}, rd);
            chk("cfg outs", {24'h0, v}, {24'h0, cfg});
        end
    endtask

    // Crossings of unselected phases must never advance the count
    task automatic t_regular();
        cfg_wr(8'h00);
        samp(24'h000005, 3'h1);
        samp(24'h000005, 3'h2);
        samp(24'h000005, 3'h4);
        chk("done masked", 32'h0, {31'h0, sd});
        acc_rd(0, 32'h0000000F);
        acc_rd(0, 32'h0000000F);
        acc_rd(14, 32'h0000000F);
    endtask

    task automatic t_clear();
        cfg_wr(8'h40);
        acc_rd(0, 32'h0000000F);
        acc_rd(3, 32'h0000000F);
        acc_rd(3, 32'h00000000);
    endtask

    // Phase B crossing must not count while only phase A is selected
    task automatic t_line();
        cfg_wr(8'h09);
        samp(24'h000003, 3'b001);
        chk("done a1", 32'h0, {31'h0, sd});
        samp(24'h000003, 3'b010);
        chk("done b", 32'h0, {31'h0, sd});
        samp(24'h000003, 3'b001);
        chk("done a2", 32'h1, {31'h0, sd});
        acc_rd(0, 32'h00000009);
        acc_rd(9, 32'h00000009);
        acc_rd(4, 32'h00000018);
    endtask

    // All three kinds in line-cycle mode, so read-with-clear stays off
    task automatic t_multi();
        cfg_wr(8'h3F);
        samp(24'h000001, 3'b011);
        chk("done two phases", 32'h1, {31'h0, sd});
        acc_rd(0, 32'h00000004);
        acc_rd(3, 32'h00000001);
        acc_rd(6, 32'h00000001);
    endtask

    task automatic t_pf();
        samp(24'h000001, 3'h0);
        chk("pf inst", 32'h1, {31'h0, sp});
        cfg_wr(8'hBD);
        samp(24'h000001, 3'h0);
        chk("pf idle", 32'h0, {31'h0, sp});
        samp(24'h000001, 3'b111);
        chk("pf period", 32'h1, {31'h0, sp});
    endtask

    // Three phases add three per crossing, so a total of eight ends on the third burst
    task automatic t_count();
        hc <= 16'h0008;
        samp(24'h000001, 3'b111);
        chk("count 3", 32'h0, {31'h0, sd});
        samp(24'h000001, 3'b111);
        chk("count 6", 32'h0, {31'h0, sp});
        samp(24'h000001, 3'b111);
        chk("count 9", 32'h1, {31'h0, sd});
        hc <= 16'h0002;
    endtask

    task automatic t_err();
        apb(1'b0, 20'h00010, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, acc_addr(0), 32'h1);
        chk("acc write err", 32'h1, {31'h0, er});
        apb(1'b0, line_cycle_mode_pkg::CFG_ADDR, 32'h0);
        chk("cfg err", 32'h0, {31'h0, er});
        chk("cfg kept", 32'h000000BD, rd);
    endtask

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_fields();
        t_regular();
        t_clear();
        t_line();
        t_multi();
        t_pf();
        t_count();
        t_err();
        results();
    end
endmodule // energy_line_cycle_mode_control_bench

// >>> hw/energy_line_cycle_mode_control.sv
// Contract
// [R01] Config bit 0 switches all total and fundamental active accumulators between regular and line-cycle accumulation.
// [R02] Config bit 1 does the same for all total and fundamental reactive accumulators.
// [R03] Config bit 2 does the same for the three per-phase apparent accumulators.
// [R04] Config bit 3 decides whether phase A zero crossings are counted for line-cycle accumulation.
// [R05] Config bit 4 decides whether phase B zero crossings are counted for line-cycle accumulation.
// [R06] Config bit 5 decides whether phase C zero crossings are counted for line-cycle accumulation.
// [R07] Crossings of every selected phase add to one count, so more phases end a period sooner.
// [R08] With bit 6 set, reading any energy accumulator returns its value and clears it.
// [R09] With bit 6 clear, reading an energy accumulator leaves it unchanged.
// [R10] Software clears bit 6 whenever bits 2 to 0 are all set.
// [R11] With bit 7 clear, power factor follows the instantaneous phase powers.
// [R12] With bit 7 set, power factor follows the line-cycle phase energies.
// [R13] Software sets bits 0 and 2 whenever it selects energy-based power factor.
// [R14] In energy-based mode the power factor updates once per programmed half-cycle count.
// [R15] In line-cycle mode energy is summed until the crossing count reaches the total, then latched.
// [R16] In regular mode every new power sample is added to the accumulator at once.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps

module energy_line_cycle_mode_control #(
    parameter int ACC_W = 32,
    parameter int SAMPLE_W = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [line_cycle_mode_pkg::ADDR_W-1:0] paddr,
    input wire logic [line_cycle_mode_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [line_cycle_mode_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic [2:0][SAMPLE_W-1:0] active_power,
    input wire logic [2:0][SAMPLE_W-1:0] reactive_power,
    input wire logic [2:0][SAMPLE_W-1:0] apparent_power,
    input wire logic [2:0][SAMPLE_W-1:0] fund_active_power,
    input wire logic [2:0][SAMPLE_W-1:0] fund_reactive_power,
    input wire logic [2:0] zero_cross,
    input wire logic [line_cycle_mode_pkg::HALF_CYCLE_W-1:0] half_cycle_count,
    output logic active_energy_cycle_sel,
    output logic reactive_energy_cycle_sel,
    output logic apparent_energy_cycle_sel,
    output logic [2:0] crossing_phase_select,
    output logic clear_on_read_en,
    output logic power_factor_source_sel,
    output logic line_cycle_done,
    output logic pf_update
);

    localparam int NACC = line_cycle_mode_pkg::NUM_ACC;
    localparam int NPH = line_cycle_mode_pkg::NUM_PHASES;
    localparam int HCW = line_cycle_mode_pkg::HALF_CYCLE_W;

    logic [7:0] line_cycle_mode_config;
    logic [ACC_W-1:0] acc [0:NACC-1];
    logic [ACC_W-1:0] work [0:NACC-1];
    logic [SAMPLE_W-1:0] sample [0:NACC-1];
    logic [ACC_W-1:0] add [0:NACC-1];
    logic [NACC-1:0] acc_lc;
    logic [NACC-1:0] rd_clear;
    logic [HCW-1:0] zx_count;
    logic [1:0] zx_inc;
    logic [HCW:0] zx_sum;
    logic setup;
    logic access;
    logic cfg_hit;
    logic acc_hit;
    logic [17:0] acc_idx;
    logic [line_cycle_mode_pkg::DATA_W-1:0] next_prdata;
    logic next_pslverr;

    assign active_energy_cycle_sel = line_cycle_mode_config[line_cycle_mode_pkg::ACTIVE_CYCLE_BIT];
    assign reactive_energy_cycle_sel =
        line_cycle_mode_config[line_cycle_mode_pkg::REACTIVE_CYCLE_BIT];
    assign apparent_energy_cycle_sel =
        line_cycle_mode_config[line_cycle_mode_pkg::APPARENT_CYCLE_BIT];
    assign crossing_phase_select = line_cycle_mode_config[line_cycle_mode_pkg::CROSS_SEL_LSB +: 3];
    assign clear_on_read_en = line_cycle_mode_config[line_cycle_mode_pkg::CLEAR_ON_READ_BIT];
    assign power_factor_source_sel = line_cycle_mode_config[line_cycle_mode_pkg::PF_SOURCE_BIT];

    // APB decode; the slave never inserts wait states
    assign pready = 1'b1;
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign cfg_hit = (paddr == line_cycle_mode_pkg::CFG_ADDR);
    assign acc_idx = paddr[line_cycle_mode_pkg::ADDR_W-1:2] - line_cycle_mode_pkg::ACC_BASE_INDEX;
    assign acc_hit = (paddr[1:0] == 2'h0) && (acc_idx < 18'(NACC));

    always_comb
    begin
        next_prdata = '0;
        next_pslverr = 1'b0;
        if (cfg_hit)
        begin
            next_prdata = {24'h000000, line_cycle_mode_config};
        end
        else if (acc_hit && !pwrite)
        begin
            next_prdata = 32'(acc[acc_idx[3:0]]);
        end
        else
        begin
            // Unmapped addresses and writes to the read-only accumulators
            next_pslverr = 1'b1;
        end
    end

    // Answer is captured in the setup cycle so it comes from a flip-flop in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            line_cycle_mode_config <= line_cycle_mode_pkg::CFG_RESET;
        end
        else if (access && pwrite && cfg_hit && pstrb[0])
        begin
            line_cycle_mode_config <= pwdata[7:0];
        end
    end

    // All selected phases feed one counter; a simultaneous overshoot is dropped at restart
    assign zx_inc = 2'(zero_cross[0] && crossing_phase_select[0])   // see [R04]
        + 2'(zero_cross[1] && crossing_phase_select[1])               // see [R05]
        + 2'(zero_cross[2] && crossing_phase_select[2]);              // see [R06]
    assign zx_sum = {1'b0, zx_count} + {{(HCW-1){1'b0}}, zx_inc};     // see [R07]
    // A zero total never closes a period
    assign line_cycle_done = (half_cycle_count != '0) && (zx_inc != 2'h0)
        && (zx_sum >= {1'b0, half_cycle_count});

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            zx_count <= '0;
        end
        else if (line_cycle_done)
        begin
            zx_count <= '0;                                            // see [R15]
        end
        else
        begin
            zx_count <= zx_sum[HCW-1:0];
        end
    end

    // Power factor refresh: per sample, or per line-cycle period in energy mode
    assign pf_update = power_factor_source_sel ? line_cycle_done : sample_valid; // see [R11] [R12] [R14]

    genvar gi;
    genvar gp;
    generate
        for (gp = 0; gp < NPH; gp++)
        begin : g_map
            assign sample[line_cycle_mode_pkg::KIND_ACTIVE*NPH+gp] = active_power[gp];
            assign sample[line_cycle_mode_pkg::KIND_REACTIVE*NPH+gp] = reactive_power[gp];
            assign sample[line_cycle_mode_pkg::KIND_APPARENT*NPH+gp] = apparent_power[gp];
            assign sample[line_cycle_mode_pkg::KIND_FUND_ACTIVE*NPH+gp] = fund_active_power[gp];
            assign sample[line_cycle_mode_pkg::KIND_FUND_REACTIVE*NPH+gp] =
                fund_reactive_power[gp];
            assign acc_lc[line_cycle_mode_pkg::KIND_ACTIVE*NPH+gp] =
                active_energy_cycle_sel;                               // see [R01]
            assign acc_lc[line_cycle_mode_pkg::KIND_FUND_ACTIVE*NPH+gp] =
                active_energy_cycle_sel;                               // see [R01]
            assign acc_lc[line_cycle_mode_pkg::KIND_REACTIVE*NPH+gp] =
                reactive_energy_cycle_sel;                             // see [R02]
            assign acc_lc[line_cycle_mode_pkg::KIND_FUND_REACTIVE*NPH+gp] =
                reactive_energy_cycle_sel;                             // see [R02]
            assign acc_lc[line_cycle_mode_pkg::KIND_APPARENT*NPH+gp] =
                apparent_energy_cycle_sel;                             // see [R03]
        end

        for (gi = 0; gi < NACC; gi++)
        begin : g_acc
            assign add[gi] = sample_valid
                ? {{(ACC_W-SAMPLE_W){sample[gi][SAMPLE_W-1]}}, sample[gi]} : '0;
            assign rd_clear[gi] = access && !pwrite && acc_hit
                && (acc_idx == 18'(gi)) && clear_on_read_en;           // see [R08] [R09]

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    work[gi] <= '0;
                end
                else if (!acc_lc[gi] || line_cycle_done)
                begin
                    work[gi] <= acc_lc[gi] ? add[gi] : '0;
                end
                else
                begin
                    work[gi] <= work[gi] + add[gi];
                end
            end

            // Clearing subtracts the value handed out, so a sample arriving meanwhile survives
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    acc[gi] <= '0;
                end
                else if (!acc_lc[gi])
                begin
                    acc[gi] <= (rd_clear[gi] ? acc[gi] - prdata[ACC_W-1:0] : acc[gi])
                        + add[gi];                                     // see [R16] [R08]
                end
                else if (line_cycle_done)
                begin
                    acc[gi] <= work[gi] + add[gi];                     // see [R15]
                end
                else if (rd_clear[gi])
                begin
                    acc[gi] <= acc[gi] - prdata[ACC_W-1:0];            // see [R08]
                end
            end
        end
    endgenerate

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_quiet_acc0;
        !sample_valid && !line_cycle_done;
    endsequence

    sequence s_read_acc0;
        access && !pwrite && acc_hit && (acc_idx == 18'h0) && (acc[0] == prdata[ACC_W-1:0]);
    endsequence

    chk_regular_add: assert property ( // see [R16] [R01]
        !active_energy_cycle_sel && sample_valid && !rd_clear[0]
        |=> acc[0] == $past(acc[0] + add[0]))
        else $error("regular active accumulator did not add the sample");

    chk_lc_hold: assert property ( // see [R15] [R01]
        active_energy_cycle_sel && !line_cycle_done && !rd_clear[0]
        ##1 active_energy_cycle_sel |-> $stable(acc[0]))
        else $error("line-cycle accumulator changed inside a period");

    chk_lc_latch: assert property ( // see [R02] [R15]
        reactive_energy_cycle_sel && line_cycle_done
        |=> acc[NPH] == $past(work[NPH] + add[NPH]))
        else $error("reactive line-cycle result not latched");

    chk_apparent_regular: assert property ( // see [R03]
        !apparent_energy_cycle_sel && !sample_valid && !rd_clear[2*NPH]
        ##1 !apparent_energy_cycle_sel |-> $stable(acc[2*NPH]))
        else $error("apparent accumulator moved without a sample");

    chk_phase_a_mask: assert property ( // see [R04]
        zero_cross == 3'h1 && !crossing_phase_select[0] |=> $stable(zx_count))
        else $error("masked phase A crossing was counted");

    chk_zx_sum: assert property ( // see [R07]
        !line_cycle_done && zero_cross == 3'h7 && crossing_phase_select == 3'h7
        |=> zx_count == $past(zx_count) + 16'h0003)
        else $error("crossings of all phases not summed");

    chk_read_clear: assert property ( // see [R08]
        s_read_acc0 and (clear_on_read_en && !active_energy_cycle_sel && !sample_valid)
        |=> acc[0] == '0 ##1 (s_quiet_acc0 or 1'b1))
        else $error("read with clear left a value behind");

    chk_read_keep: assert property ( // see [R09]
        s_read_acc0 and (!clear_on_read_en) and s_quiet_acc0 |=> $stable(acc[0]))
        else $error("plain read disturbed the accumulator");

    chk_pf_energy: assert property ( // see [R14] [R12]
        power_factor_source_sel |-> pf_update == line_cycle_done)
        else $error("energy power factor update not tied to period end");

    chk_pf_instant: assert property ( // see [R11]
        !power_factor_source_sel |-> pf_update == sample_valid)
        else $error("instantaneous power factor update not per sample");

    chk_done_restart: assert property ( // see [R15]
        line_cycle_done |=> zx_count == '0)
        else $error("crossing count not restarted after period end");

    // Each phase is checked alone, so a swapped select bit shows up as a wrong count
    chk_phase_a_count: assert property ( // see [R04]
        zero_cross == 3'h1 && crossing_phase_select[0] && !line_cycle_done
        |=> zx_count == $past(zx_count) + 16'h0001)
        else $error("selected phase A crossing was not counted");

    chk_phase_b_mask: assert property ( // see [R05]
        zero_cross == 3'h2 && !crossing_phase_select[1] |=> $stable(zx_count))
        else $error("masked phase B crossing was counted");

    chk_phase_c_mask: assert property ( // see [R06]
        zero_cross == 3'h4 && !crossing_phase_select[2] |=> $stable(zx_count))
        else $error("masked phase C crossing was counted");

    chk_fund_latch: assert property ( // see [R01] [R15]
        active_energy_cycle_sel && line_cycle_done
        |=> acc[3*NPH] == $past(work[3*NPH] + add[3*NPH]))
        else $error("fundamental active line-cycle result not latched");

    chk_fund_reactive_add: assert property ( // see [R02] [R16]
        !reactive_energy_cycle_sel && sample_valid && !rd_clear[4*NPH]
        |=> acc[4*NPH] == $past(acc[4*NPH] + add[4*NPH]))
        else $error("regular fundamental reactive accumulator did not add the sample");

    chk_apparent_latch: assert property ( // see [R03] [R15]
        apparent_energy_cycle_sel && line_cycle_done
        |=> acc[2*NPH] == $past(work[2*NPH] + add[2*NPH]))
        else $error("apparent line-cycle result not latched");

    chk_period_restart: assert property ( // see [R15]
        active_energy_cycle_sel && line_cycle_done |=> work[0] == $past(add[0]))
        else $error("new period did not start from the closing sample");

    // Every mode output follows the register, so a lost write breaks all of them
    chk_cfg_write: assert property ( // see [R08] [R12]
        access && pwrite && cfg_hit && pstrb[0]
        |=> line_cycle_mode_config == $past(pwdata[7:0]))
        else $error("config write did not land");

    chk_cfg_hold: assert property ( // see [R09] [R11]
        !(access && pwrite && cfg_hit && pstrb[0]) |=> $stable(line_cycle_mode_config))
        else $error("config changed without a write");

endmodule // energy_line_cycle_mode_control

// >>> hw/line_cycle_mode_pkg.sv
package line_cycle_mode_pkg;
    // Bus geometry: printed offsets are word indexes, byte address is four times that
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam logic [17:0] CFG_INDEX = 18'h0E702;
    localparam logic [ADDR_W-1:0] CFG_ADDR = {CFG_INDEX, 2'b00};
    localparam logic [17:0] ACC_BASE_INDEX = 18'h0E400;

    // Accumulator layout: index = kind * NUM_PHASES + phase
    localparam int NUM_PHASES = 3;
    localparam int NUM_KINDS = 5;
    localparam int NUM_ACC = NUM_KINDS * NUM_PHASES;
    localparam int KIND_ACTIVE = 0;
    localparam int KIND_REACTIVE = 1;
    localparam int KIND_APPARENT = 2;
    localparam int KIND_FUND_ACTIVE = 3;
    localparam int KIND_FUND_REACTIVE = 4;

    // Field positions of line_cycle_mode_config
    localparam int ACTIVE_CYCLE_BIT = 0;
    localparam int REACTIVE_CYCLE_BIT = 1;
    localparam int APPARENT_CYCLE_BIT = 2;
    localparam int CROSS_SEL_LSB = 3;
    localparam int CLEAR_ON_READ_BIT = 6;
    localparam int PF_SOURCE_BIT = 7;
    localparam logic [7:0] CFG_RESET = 8'h78;

    localparam int HALF_CYCLE_W = 16;
endpackage
